// ===== verilog/fpp_regs.svh
// Purpose: offsets, field positions and reset values of the pin polarity bank
// Assumes: register index times four gives the APB byte address
// Notes: definitions only
`ifndef FPP_REGS_SVH
`define FPP_REGS_SVH

// register indices
`define FPP_TXCLK_IDX 6'h02
`define FPP_TXSYS_IDX 6'h03
`define FPP_RXSYS_IDX 6'h04
`define FPP_LINE_IDX 6'h05
`define FPP_ISUM_IDX 6'h06

// reset values and masks
`define FPP_TXCLK_RST 8'h00
`define FPP_TXSYS_RST 8'h00
`define FPP_RXSYS_RST 8'h10
`define FPP_LINE_RST 8'h00
`define FPP_TXCLK_MASK 8'h40
`define FPP_ISUM_MASK 8'h0F

// tx clock control fields
`define FPP_TX_CONST_CLK 6

// tx system fields
`define FPP_TX_EN_INV 0
`define FPP_TX_DATA_INV 1
`define FPP_TX_ICLK_INV 2
`define FPP_TX_FS_INV 3
`define FPP_TX_OH_INV 4
`define FPP_TX_OHEN_INV 5
`define FPP_TX_FS_DIR 6
`define FPP_TX_EN_MODE 7

// rx system fields
`define FPP_RX_EN_INV 0
`define FPP_RX_DATA_INV 1
`define FPP_RX_OCLK_INV 2
`define FPP_RX_FS_INV 3
`define FPP_RX_FORCE_HIGH 4
`define FPP_RX_LOS_INV 5
`define FPP_RX_OOF_INV 6
`define FPP_RX_EN_MODE 7

// line fields
`define FPP_TX_LINE_CLOCK_INV 0
`define FPP_TX_POSITIVE_RAIL_INV 1
`define FPP_TX_NEGATIVE_RAIL_INV 2
`define FPP_TX_POSITIVE_RAIL_FH 3
`define FPP_TX_NEGATIVE_RAIL_FH 4
`define FPP_RCLK_INV 5
`define FPP_RX_POSITIVE_RAIL_INV 6
`define FPP_RX_NEGATIVE_RAIL_INV 7

`endif

// ===== verilog/fpp_pkg.sv
// Purpose: types shared by the pin polarity bank
// Assumes: field order matches the inversion masks built in the bank
// Notes: none
package fpp_pkg;

  // pins arriving from outside, synchronised before use
  typedef struct packed {
    logic rx_negative_rail;
    logic rx_positive_rail;
    logic rx_line_clock;
    logic tx_overhead_enable;
    logic tx_overhead_data;
    logic tx_frame_start;
    logic tx_input_clock;
    logic tx_payload_in;
  } fpp_pins_in_t;

  // framer core signals on pclk
  typedef struct packed {
    logic tx_bit_clock;
    logic tx_payload_slot;
    logic tx_frame_last;
    logic tx_line_clock;
    logic tx_positive_rail;
    logic tx_negative_rail;
    logic rx_bit_clock;
    logic rx_payload_slot;
    logic rx_payload;
    logic rx_frame_start;
    logic rx_loss_of_signal;
    logic rx_out_of_frame;
  } fpp_core_in_t;

  // system and line pins driven by the bank
  typedef struct packed {
    logic tx_payload_enable;
    logic tx_frame_start_out;
    logic tx_frame_start_oe;
    logic rx_payload_enable;
    logic rx_payload_out;
    logic rx_output_clock;
    logic rx_frame_start;
    logic rx_loss_of_signal;
    logic rx_out_of_frame;
    logic tx_line_clock;
    logic tx_positive_rail;
    logic tx_negative_rail;
  } fpp_pins_out_t;

  typedef struct packed {
    logic [7:0] tx_clk_ctl_reg;
    logic [7:0] tx_sys_reg;
    logic [7:0] rx_sys_reg;
    logic [7:0] line_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    fpp_pins_in_t sync1_reg;
    fpp_pins_in_t sync2_reg;
    fpp_pins_in_t core_pins_reg;
    fpp_pins_out_t pins_out_reg;
  } fpp_state_t;

endpackage : fpp_pkg

// ===== verilog/fpp_bank.sv
// Purpose: pin polarity and pin function bank of one framer, APB slave
// Assumes: core signals share pclk; pins from outside pass two synchroniser flops and an inversion flop
// Notes: zero wait states, pready is always high
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "fpp_regs.svh"

module fpp_bank
  import fpp_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // framer side
  input wire fpp_core_in_t core_in,
  input wire logic [3:0] framer_irq_drive,
  output fpp_pins_in_t core_pins,
  // pins
  input wire fpp_pins_in_t pins_in,
  output fpp_pins_out_t pins_out
);

  fpp_state_t st_q;
  fpp_state_t st_d;

  // decode of a byte address to a register index; shared by read and write
  function automatic logic [5:0] fpp_index(input logic [7:0] addr);
    fpp_index = addr[7:2];
  endfunction : fpp_index

  function automatic logic fpp_mapped(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    fpp_mapped = (addr[1:0] == 2'h0) && (idx >= `FPP_TXCLK_IDX) && (idx <= `FPP_ISUM_IDX);
  endfunction : fpp_mapped

  logic wr_take;
  logic rd_setup;
  logic tx_clk_sel;
  logic tx_gate;
  logic rx_gate;
  fpp_pins_in_t in_inv_mask;

  assign pready = 1'b1;
  assign prdata = st_q.prdata_reg;
  assign pslverr = st_q.pslverr_reg;
  assign core_pins = st_q.core_pins_reg;
  assign pins_out = st_q.pins_out_reg;

  assign wr_take = psel && penable && pwrite && fpp_mapped(paddr);
  assign rd_setup = psel && !penable;

  always_comb begin
    st_d = st_q;
    // register writes; summary index ignores writes
    if (wr_take) begin
      case (fpp_index(paddr))
        `FPP_TXCLK_IDX: st_d.tx_clk_ctl_reg = pwdata[7:0] & `FPP_TXCLK_MASK;
        `FPP_TXSYS_IDX: st_d.tx_sys_reg = pwdata[7:0];
        `FPP_RXSYS_IDX: st_d.rx_sys_reg = pwdata[7:0];
        `FPP_LINE_IDX: st_d.line_reg = pwdata[7:0];
        default: st_d.tx_sys_reg = st_q.tx_sys_reg;
      endcase
    end
    // read data is captured in setup so it is stable through access
    if (rd_setup) begin
      st_d.prdata_reg = 32'h0000_0000;
      st_d.pslverr_reg = !fpp_mapped(paddr);
      case (fpp_index(paddr))
        `FPP_TXCLK_IDX: st_d.prdata_reg[7:0] = st_q.tx_clk_ctl_reg;
        `FPP_TXSYS_IDX: st_d.prdata_reg[7:0] = st_q.tx_sys_reg;
        `FPP_RXSYS_IDX: st_d.prdata_reg[7:0] = st_q.rx_sys_reg;
        `FPP_LINE_IDX: st_d.prdata_reg[7:0] = st_q.line_reg;
        `FPP_ISUM_IDX: st_d.prdata_reg[7:0] = {4'h0, framer_irq_drive};
        default: st_d.prdata_reg = 32'h0000_0000;
      endcase
    end
    // two-flop synchronisers; stage one feeds stage two only
    st_d.sync1_reg = pins_in;
    st_d.sync2_reg = st_q.sync1_reg;
    st_d.core_pins_reg = st_q.sync2_reg ^ in_inv_mask;
    // transmit system pins
    st_d.pins_out_reg.tx_payload_enable = tx_gate ^ st_q.tx_sys_reg[`FPP_TX_EN_INV];
    st_d.pins_out_reg.tx_frame_start_oe = st_q.tx_sys_reg[`FPP_TX_FS_DIR];
    st_d.pins_out_reg.tx_frame_start_out =
      core_in.tx_frame_last ^ st_q.tx_sys_reg[`FPP_TX_FS_INV];
    // receive system pins
    st_d.pins_out_reg.rx_payload_enable = rx_gate ^ st_q.rx_sys_reg[`FPP_RX_EN_INV];
    st_d.pins_out_reg.rx_payload_out =
      (core_in.rx_payload | st_q.rx_sys_reg[`FPP_RX_FORCE_HIGH])
      ^ st_q.rx_sys_reg[`FPP_RX_DATA_INV];
    st_d.pins_out_reg.rx_output_clock =
      core_in.rx_bit_clock ^ st_q.rx_sys_reg[`FPP_RX_OCLK_INV];
    st_d.pins_out_reg.rx_frame_start =
      core_in.rx_frame_start ^ st_q.rx_sys_reg[`FPP_RX_FS_INV];
    st_d.pins_out_reg.rx_loss_of_signal =
      core_in.rx_loss_of_signal ^ st_q.rx_sys_reg[`FPP_RX_LOS_INV];
    st_d.pins_out_reg.rx_out_of_frame =
      core_in.rx_out_of_frame ^ st_q.rx_sys_reg[`FPP_RX_OOF_INV];
    // line pins
    st_d.pins_out_reg.tx_line_clock = core_in.tx_line_clock ^ st_q.line_reg[`FPP_TX_LINE_CLOCK_INV];
    st_d.pins_out_reg.tx_positive_rail =
      (core_in.tx_positive_rail | st_q.line_reg[`FPP_TX_POSITIVE_RAIL_FH])
      ^ st_q.line_reg[`FPP_TX_POSITIVE_RAIL_INV];
    st_d.pins_out_reg.tx_negative_rail =
      (core_in.tx_negative_rail | st_q.line_reg[`FPP_TX_NEGATIVE_RAIL_FH])
      ^ st_q.line_reg[`FPP_TX_NEGATIVE_RAIL_INV];
  end

  // per-pin inversion of the synchronised inputs
  always_comb begin
    in_inv_mask = '0;
    in_inv_mask.tx_payload_in = st_q.tx_sys_reg[`FPP_TX_DATA_INV];
    in_inv_mask.tx_input_clock = st_q.tx_sys_reg[`FPP_TX_ICLK_INV];
    in_inv_mask.tx_frame_start = st_q.tx_sys_reg[`FPP_TX_FS_INV];
    in_inv_mask.tx_overhead_data = st_q.tx_sys_reg[`FPP_TX_OH_INV];
    in_inv_mask.tx_overhead_enable = st_q.tx_sys_reg[`FPP_TX_OHEN_INV];
    in_inv_mask.rx_line_clock = st_q.line_reg[`FPP_RCLK_INV];
    in_inv_mask.rx_positive_rail = st_q.line_reg[`FPP_RX_POSITIVE_RAIL_INV];
    in_inv_mask.rx_negative_rail = st_q.line_reg[`FPP_RX_NEGATIVE_RAIL_INV];
  end

  // shared enable or gapped clock; constant clock wins over the mode bit
  always_comb begin
    tx_clk_sel = st_q.tx_clk_ctl_reg[`FPP_TX_CONST_CLK];
    if (tx_clk_sel) begin
      tx_gate = core_in.tx_bit_clock;
    end else if (st_q.tx_sys_reg[`FPP_TX_EN_MODE]) begin
      tx_gate = core_in.tx_bit_clock & core_in.tx_payload_slot;
    end else begin
      tx_gate = core_in.tx_payload_slot;
    end
    if (st_q.rx_sys_reg[`FPP_RX_EN_MODE]) begin
      rx_gate = core_in.rx_bit_clock & core_in.rx_payload_slot;
    end else begin
      rx_gate = core_in.rx_payload_slot;
    end
  end

  // the frame-start pin defaults to input so nothing fights an external driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.tx_clk_ctl_reg <= `FPP_TXCLK_RST;
      st_q.tx_sys_reg <= `FPP_TXSYS_RST;
      st_q.rx_sys_reg <= `FPP_RXSYS_RST;
      st_q.line_reg <= `FPP_LINE_RST;
      st_q.pins_out_reg.rx_payload_out <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking fpp_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_isum_setup;
    psel && !penable && !pwrite && (paddr == {`FPP_ISUM_IDX, 2'h0});
  endsequence

  sequence s_access_done;
    psel && penable && pready;
  endsequence

  a_fs_output_dir: assert property (
    st_q.tx_sys_reg[`FPP_TX_FS_DIR] && core_in.tx_frame_last
    |=> pins_out.tx_frame_start_oe
      && (pins_out.tx_frame_start_out != $past(st_q.tx_sys_reg[`FPP_TX_FS_INV])))
    else $error("frame start not driven on last cycle");

  a_fs_input_dir: assert property (
    !st_q.tx_sys_reg[`FPP_TX_FS_DIR] |=> !pins_out.tx_frame_start_oe)
    else $error("frame start driven while input");

  a_tx_enable_mode: assert property (
    !st_q.tx_clk_ctl_reg[`FPP_TX_CONST_CLK] && !st_q.tx_sys_reg[`FPP_TX_EN_MODE]
    |=> pins_out.tx_payload_enable
      == ($past(core_in.tx_payload_slot) ^ $past(st_q.tx_sys_reg[`FPP_TX_EN_INV])))
    else $error("tx enable level wrong");

  a_tx_gapped_clk: assert property (
    !st_q.tx_clk_ctl_reg[`FPP_TX_CONST_CLK] && st_q.tx_sys_reg[`FPP_TX_EN_MODE]
    && !core_in.tx_payload_slot && !st_q.tx_sys_reg[`FPP_TX_EN_INV]
    |=> !pins_out.tx_payload_enable)
    else $error("gapped clock not suppressed in overhead");

  a_tx_const_clk: assert property (
    st_q.tx_clk_ctl_reg[`FPP_TX_CONST_CLK] && !core_in.tx_payload_slot
    && core_in.tx_bit_clock
    |=> pins_out.tx_payload_enable != $past(st_q.tx_sys_reg[`FPP_TX_EN_INV]))
    else $error("constant clock gated by payload slot");

  a_rx_gapped_clk: assert property (
    st_q.rx_sys_reg[`FPP_RX_EN_MODE] && !core_in.rx_payload_slot
    |=> pins_out.rx_payload_enable == $past(st_q.rx_sys_reg[`FPP_RX_EN_INV]))
    else $error("rx gapped clock not suppressed");

  a_rx_force_low: assert property (
    st_q.rx_sys_reg[`FPP_RX_FORCE_HIGH] && st_q.rx_sys_reg[`FPP_RX_DATA_INV]
    |=> !pins_out.rx_payload_out)
    else $error("rx data not forced low");

  a_rx_force_high: assert property (
    st_q.rx_sys_reg[`FPP_RX_FORCE_HIGH] && !st_q.rx_sys_reg[`FPP_RX_DATA_INV]
    |=> pins_out.rx_payload_out)
    else $error("rx data not forced high");

  a_tx_positive_rail_force: assert property (
    st_q.line_reg[`FPP_TX_POSITIVE_RAIL_FH]
    |=> pins_out.tx_positive_rail == !$past(st_q.line_reg[`FPP_TX_POSITIVE_RAIL_INV]))
    else $error("positive rail force wrong");

  a_tx_negative_rail_force: assert property (
    st_q.line_reg[`FPP_TX_NEGATIVE_RAIL_FH]
    |=> pins_out.tx_negative_rail == !$past(st_q.line_reg[`FPP_TX_NEGATIVE_RAIL_INV]))
    else $error("negative rail force wrong");

  a_isum_read: assert property (
    s_isum_setup ##1 s_access_done
    |-> prdata == {28'h0, $past(framer_irq_drive)} && !pslverr)
    else $error("summary read data wrong");

  a_isum_no_write: assert property (
    psel && penable && pwrite && (paddr == {`FPP_ISUM_IDX, 2'h0})
    |=> $stable(st_q.tx_sys_reg) && $stable(st_q.rx_sys_reg) && $stable(st_q.line_reg))
    else $error("summary write altered a register");

  a_isum_read_clean: assert property (
    s_isum_setup ##1 s_access_done
    |=> $stable(st_q.tx_sys_reg) && $stable(st_q.rx_sys_reg) && $stable(st_q.line_reg))
    else $error("summary read altered a register");

  a_tx_data_inv: assert property (
    core_pins.tx_payload_in
    == ($past(st_q.sync2_reg.tx_payload_in) ^ $past(st_q.tx_sys_reg[`FPP_TX_DATA_INV])))
    else $error("tx data inversion wrong");

  a_tx_iclk_inv: assert property (
    core_pins.tx_input_clock
    == ($past(st_q.sync2_reg.tx_input_clock) ^ $past(st_q.tx_sys_reg[`FPP_TX_ICLK_INV])))
    else $error("tx input clock inversion wrong");

  a_tx_fs_in_inv: assert property (
    core_pins.tx_frame_start
    == ($past(st_q.sync2_reg.tx_frame_start) ^ $past(st_q.tx_sys_reg[`FPP_TX_FS_INV])))
    else $error("tx frame start input inversion wrong");

  a_tx_oh_inv: assert property (
    core_pins.tx_overhead_data
    == ($past(st_q.sync2_reg.tx_overhead_data) ^ $past(st_q.tx_sys_reg[`FPP_TX_OH_INV])))
    else $error("tx overhead data inversion wrong");

  a_tx_ohen_inv: assert property (
    core_pins.tx_overhead_enable
    == ($past(st_q.sync2_reg.tx_overhead_enable) ^ $past(st_q.tx_sys_reg[`FPP_TX_OHEN_INV])))
    else $error("tx overhead enable inversion wrong");

  a_rx_lclk_inv: assert property (
    core_pins.rx_line_clock
    == ($past(st_q.sync2_reg.rx_line_clock) ^ $past(st_q.line_reg[`FPP_RCLK_INV])))
    else $error("rx line clock inversion wrong");

  a_rx_pos_inv: assert property (
    core_pins.rx_positive_rail
    == ($past(st_q.sync2_reg.rx_positive_rail) ^ $past(st_q.line_reg[`FPP_RX_POSITIVE_RAIL_INV])))
    else $error("rx positive rail inversion wrong");

  a_rx_neg_inv: assert property (
    core_pins.rx_negative_rail
    == ($past(st_q.sync2_reg.rx_negative_rail) ^ $past(st_q.line_reg[`FPP_RX_NEGATIVE_RAIL_INV])))
    else $error("rx negative rail inversion wrong");

  a_rx_oclk_inv: assert property (
    pins_out.rx_output_clock
    == ($past(core_in.rx_bit_clock) ^ $past(st_q.rx_sys_reg[`FPP_RX_OCLK_INV])))
    else $error("rx output clock inversion wrong");

  a_rx_fs_inv: assert property (
    pins_out.rx_frame_start
    == ($past(core_in.rx_frame_start) ^ $past(st_q.rx_sys_reg[`FPP_RX_FS_INV])))
    else $error("rx frame start inversion wrong");

  a_rx_los_inv: assert property (
    pins_out.rx_loss_of_signal
    == ($past(core_in.rx_loss_of_signal) ^ $past(st_q.rx_sys_reg[`FPP_RX_LOS_INV])))
    else $error("rx loss of signal inversion wrong");

  a_rx_oof_inv: assert property (
    pins_out.rx_out_of_frame
    == ($past(core_in.rx_out_of_frame) ^ $past(st_q.rx_sys_reg[`FPP_RX_OOF_INV])))
    else $error("rx out of frame inversion wrong");

  a_rx_enable_mode: assert property (
    !st_q.rx_sys_reg[`FPP_RX_EN_MODE]
    |=> pins_out.rx_payload_enable
      == ($past(core_in.rx_payload_slot) ^ $past(st_q.rx_sys_reg[`FPP_RX_EN_INV])))
    else $error("rx enable level wrong");

  a_rx_data_pass: assert property (
    !st_q.rx_sys_reg[`FPP_RX_FORCE_HIGH]
    |=> pins_out.rx_payload_out
      == ($past(core_in.rx_payload) ^ $past(st_q.rx_sys_reg[`FPP_RX_DATA_INV])))
    else $error("rx data inversion wrong");

  a_tx_line_clock_inv: assert property (
    pins_out.tx_line_clock
    == ($past(core_in.tx_line_clock) ^ $past(st_q.line_reg[`FPP_TX_LINE_CLOCK_INV])))
    else $error("tx line clock inversion wrong");

  a_tx_positive_rail_pass: assert property (
    !st_q.line_reg[`FPP_TX_POSITIVE_RAIL_FH]
    |=> pins_out.tx_positive_rail
      == ($past(core_in.tx_positive_rail) ^ $past(st_q.line_reg[`FPP_TX_POSITIVE_RAIL_INV])))
    else $error("positive rail inversion wrong");

  a_tx_negative_rail_pass: assert property (
    !st_q.line_reg[`FPP_TX_NEGATIVE_RAIL_FH]
    |=> pins_out.tx_negative_rail
      == ($past(core_in.tx_negative_rail) ^ $past(st_q.line_reg[`FPP_TX_NEGATIVE_RAIL_INV])))
    else $error("negative rail inversion wrong");

  a_tx_gapped_pulse: assert property (
    !st_q.tx_clk_ctl_reg[`FPP_TX_CONST_CLK] && st_q.tx_sys_reg[`FPP_TX_EN_MODE]
    && core_in.tx_payload_slot && core_in.tx_bit_clock
    |=> pins_out.tx_payload_enable != $past(st_q.tx_sys_reg[`FPP_TX_EN_INV]))
    else $error("gapped clock pulse missing in payload");

  a_const_clk_low: assert property (
    st_q.tx_clk_ctl_reg[`FPP_TX_CONST_CLK] && !core_in.tx_bit_clock
    |=> pins_out.tx_payload_enable == $past(st_q.tx_sys_reg[`FPP_TX_EN_INV]))
    else $error("constant clock not following bit clock");

  // last frame cycle seen, then the next cycle is not the last one
  sequence s_fs_last_beat;
    st_q.tx_sys_reg[`FPP_TX_FS_DIR] && core_in.tx_frame_last
    ##1 st_q.tx_sys_reg[`FPP_TX_FS_DIR] && !core_in.tx_frame_last;
  endsequence

  sequence s_fs_pulse_ends;
    pins_out.tx_frame_start_oe
    && (pins_out.tx_frame_start_out == $past(st_q.tx_sys_reg[`FPP_TX_FS_INV]));
  endsequence

  a_fs_pulse_end: assert property (
    s_fs_last_beat |=> s_fs_pulse_ends)
    else $error("frame start pulse longer than one cycle");

endmodule : fpp_bank

// ===== tb/fpp_host.sv
// Purpose: apb master standing in for the host processor
// Assumes: pready is looked at on rising edges only
// Notes: released address and data lines go to the inverse of their last value
`timescale 1ns/1ps
module fpp_host (
  // clock
  input wire logic pclk,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // no wait count assumed; only the bench watchdog ends a stall
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : fpp_host

// ===== tb/test_fpp_bank.sv
// Purpose: self-checking bench of the pin polarity bank
// Assumes: pins settle within four cycles of a stable input
// Notes: pin expectations rebuilt from shadow copies of the registers
`timescale 1ns/1ps
`include "fpp_regs.svh"
module test_fpp_bank import fpp_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  fpp_core_in_t core_in = '0;
  logic [3:0] framer_irq_drive = 4'h0;
  fpp_pins_in_t pins_in = '0;
  fpp_pins_in_t core_pins;
  fpp_pins_out_t pins_out;
  logic [7:0] txc = 8'h00, txs = 8'h00, rxs = 8'h10, lin = 8'h00;
  int err_count = 0;
  int checks = 0;

  always #50 pclk = ~pclk;

  fpp_bank fpp_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_in(core_in), .framer_irq_drive(framer_irq_drive),
    .core_pins(core_pins), .pins_in(pins_in), .pins_out(pins_out));
  fpp_host fpp_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t pin got %b expected %b", $time, g, e);
    end
  endtask : chk

  task automatic chkr(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t value got %h expected %h", $time, g, e);
    end
  endtask : chkr

  task automatic rd_chk(input logic [5:0] i, input logic [31:0] e, input logic se);
    logic [31:0] q;
    logic er;
    fpp_host_inst.xfer(1'b0, {i, 2'b00}, 32'h0, q, er);
    chkr(q, e);
    chkr({31'h0, er}, {31'h0, se});
  endtask : rd_chk

  task automatic set_reg(input logic [5:0] i, input logic [7:0] v);
    logic [31:0] q;
    logic er;
    fpp_host_inst.xfer(1'b1, {i, 2'b00}, {24'h000000, v}, q, er);
    case (i)
      `FPP_TXCLK_IDX: txc = v & `FPP_TXCLK_MASK;
      `FPP_TXSYS_IDX: txs = v;
      `FPP_RXSYS_IDX: rxs = v;
      `FPP_LINE_IDX: lin = v;
      default: ;
    endcase
  endtask : set_reg

  task automatic check_pins();
    logic g;
    repeat (4) @(posedge pclk);
    #1;
    g = txs[7] ? core_in.tx_bit_clock & core_in.tx_payload_slot : core_in.tx_payload_slot;
    if (txc[6]) g = core_in.tx_bit_clock;
    chk(pins_out.tx_payload_enable, g ^ txs[0]);
    chk(pins_out.tx_frame_start_oe, txs[6]);
    if (txs[6])
      chk(pins_out.tx_frame_start_out, core_in.tx_frame_last ^ txs[3]);
    g = rxs[7] ? core_in.rx_bit_clock & core_in.rx_payload_slot : core_in.rx_payload_slot;
    chk(pins_out.rx_payload_enable, g ^ rxs[0]);
    chk(pins_out.rx_payload_out, (core_in.rx_payload | rxs[4]) ^ rxs[1]);
    chk(pins_out.rx_output_clock, core_in.rx_bit_clock ^ rxs[2]);
    chk(pins_out.rx_frame_start, core_in.rx_frame_start ^ rxs[3]);
    chk(pins_out.rx_loss_of_signal, core_in.rx_loss_of_signal ^ rxs[5]);
    chk(pins_out.rx_out_of_frame, core_in.rx_out_of_frame ^ rxs[6]);
    chk(pins_out.tx_line_clock, core_in.tx_line_clock ^ lin[0]);
    chk(pins_out.tx_positive_rail, (core_in.tx_positive_rail | lin[3]) ^ lin[1]);
    chk(pins_out.tx_negative_rail, (core_in.tx_negative_rail | lin[4]) ^ lin[2]);
    chkr({24'h0, core_pins}, {24'h0, pins_in ^ {lin[7:5], txs[5:1]}});
  endtask : check_pins

  // sixteen input patterns reach every clock and slot pairing
  task automatic sweep(input logic [5:0] i, input logic [7:0] v);
    set_reg(i, v);
    for (int k = 0; k < 16; k++) begin
      @(posedge pclk);
      core_in <= fpp_core_in_t'({3{k[3:0]}});
      pins_in <= fpp_pins_in_t'({2{~k[3:0]}});
      check_pins();
    end
  endtask : sweep

  task automatic t_reset();
    check_pins();
    rd_chk(`FPP_TXCLK_IDX, {24'h0, `FPP_TXCLK_RST}, 1'b0);
    rd_chk(`FPP_TXSYS_IDX, {24'h0, `FPP_TXSYS_RST}, 1'b0);
    rd_chk(`FPP_RXSYS_IDX, {24'h0, `FPP_RXSYS_RST}, 1'b0);
    rd_chk(`FPP_LINE_IDX, {24'h0, `FPP_LINE_RST}, 1'b0);
    rd_chk(6'h07, 32'h0, 1'b1);
  endtask : t_reset

  task automatic t_regs();
    set_reg(`FPP_TXCLK_IDX, 8'hFF);
    rd_chk(`FPP_TXCLK_IDX, 32'h40, 1'b0);
    set_reg(`FPP_TXSYS_IDX, 8'hA5);
    rd_chk(`FPP_TXSYS_IDX, 32'hA5, 1'b0);
    set_reg(`FPP_RXSYS_IDX, 8'h5A);
    rd_chk(`FPP_RXSYS_IDX, 32'h5A, 1'b0);
    set_reg(`FPP_LINE_IDX, 8'hC3);
    rd_chk(`FPP_LINE_IDX, 32'hC3, 1'b0);
    set_reg(`FPP_ISUM_IDX, 8'hFF);
    rd_chk(`FPP_ISUM_IDX, 32'h0, 1'b0);
    rd_chk(`FPP_TXSYS_IDX, 32'hA5, 1'b0);
  endtask : t_regs

  task automatic t_isum();
    for (int p = 0; p < 16; p++) begin
      @(posedge pclk);
      framer_irq_drive <= p[3:0];
      rd_chk(`FPP_ISUM_IDX, {28'h0, p[3:0]}, 1'b0);
      rd_chk(`FPP_ISUM_IDX, {28'h0, p[3:0]}, 1'b0);
    end
  endtask : t_isum

  task automatic t_tx();
    logic [7:0] v [6] = '{8'h00, 8'h80, 8'hFF, 8'h49, 8'hB6, 8'h40};
    set_reg(`FPP_TXCLK_IDX, 8'h00);
    foreach (v[j]) sweep(`FPP_TXSYS_IDX, v[j]);
    sweep(`FPP_TXCLK_IDX, 8'h40);
    sweep(`FPP_TXSYS_IDX, 8'h81);
    sweep(`FPP_TXCLK_IDX, 8'h00);
  endtask : t_tx

  task automatic t_rx();
    logic [7:0] v [7] = '{8'h10, 8'h12, 8'h02, 8'h80, 8'hFF, 8'hEF, 8'h6D};
    foreach (v[j]) sweep(`FPP_RXSYS_IDX, v[j]);
    sweep(`FPP_RXSYS_IDX, 8'h00);
  endtask : t_rx

  task automatic t_line();
    logic [7:0] v [7] = '{8'h00, 8'hFF, 8'h18, 8'h1E, 8'hE7, 8'h01, 8'h06};
    foreach (v[j]) sweep(`FPP_LINE_IDX, v[j]);
  endtask : t_line

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_isum();
    t_tx();
    t_rx();
    t_line();
    finish_test();
  end

  // run needs about 2200 cycles; this leaves a wide margin
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    finish_test();
  end
endmodule : test_fpp_bank
